/* File: verilog/dsp_pkg.sv */
// Constants and types for the debug support port
// Function
// - Strap at reset picks debug or test port
// - Test reset clears scan logic asynchronously
// - Mode select sampled on test clock rise
// - Test data in sampled on test clock rise
// - Data out driven only in shift states
// - Serial clock rise samples in, updates out
// - Serial out comes from a register
// - Breakpoint halts after instruction completes
// - Halted core shows all-ones status
// - Breakpoint disabled raises debug interrupt instead
// - Strobe disable freezes all trace outputs
// - Re-enable restarts trace, host resynchronises
// - Strobe starts at first C, D or F
// - Strobe rises mid window of trace
// - All-status output is AND of status
// - Status updates with processor clock
// - Debug data shows captured data only
`default_nettype none
package dsp_pkg;
    // ********************************
    // Counts and codes
    // ********************************
    localparam logic [1:0]  SEL_WAIT   = 2'h2;          // Edges before strap capture
    localparam int          PKT_LEN    = 17;            // Serial packet length
    localparam logic [4:0]  PKT_LAST   = 5'h10;         // Last bit index of a packet
    localparam int          IR_LEN     = 4;             // Instruction length
    localparam logic [3:0]  IR_IDCODE  = 4'h1;          // Identity read instruction
    localparam logic [3:0]  IR_CAPTURE = 4'h1;          // Captured into IR shifter
    localparam logic [31:0] ID_CODE    = 32'h0000_0001; // Arbitrary value, bit 0 set
    localparam logic [3:0]  STAT_HALT  = 4'hF;          // Halted status code
    localparam logic [3:0]  STAT_C     = 4'hC;          // First strobe codes
    localparam logic [3:0]  STAT_D     = 4'hD;
    // ********************************
    // Types
    // ********************************
    typedef enum logic [3:0] {
        TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
        TAP_SH_DR = 4'h6, TAP_EX1_DR = 4'h7, TAP_PAU_DR = 4'h5, TAP_EX2_DR = 4'h4,
        TAP_UPD_DR = 4'hC, TAP_SEL_IR = 4'hD, TAP_CAP_IR = 4'hF, TAP_SH_IR = 4'hE,
        TAP_EX1_IR = 4'hA, TAP_PAU_IR = 4'hB, TAP_EX2_IR = 4'h9, TAP_UPD_IR = 4'h8
    } dsp_tap_state_t;
    typedef struct packed {
        logic [3:0] status;     // Core status code
        logic [3:0] cap_data;   // Captured data nibble
        logic       insn_done;  // Current instruction completes
        logic       resume;     // Leave halted state
    } dsp_core_in_t;
    typedef struct packed {
        logic [1:0]         sel_sh;
        logic [1:0]         sel_cnt;
        logic               sel_done;
        logic               jtag_mode;
        logic [2:0]         ds_sh;     // Sync, sync, previous
        logic               ds_lvl;    // Validated serial clock level
        logic [1:0]         dsi_sh;
        logic [4:0]         bit_cnt;
        logic [PKT_LEN-1:0] rx_sh;
        logic [PKT_LEN-1:0] tx_sh;
        logic [PKT_LEN-1:0] rx_data;
        logic               rx_valid;
        logic               ser_out;
        logic [2:0]         bk_sh;
        logic               halt_pend;
        logic               halted;
        logic               dbg_irq;
        logic               tr_ph;     // Trace divider phase
        logic               trace_on;
        logic               strobe;
        logic [3:0]         stat;
        logic [3:0]         dbg_data;
        logic               stat_and;
    } dsp_core_st_t;
    typedef struct packed {
        logic [2:0]        tck_sh;
        logic [1:0]        tms_sh;
        logic [1:0]        tdi_sh;
        dsp_tap_state_t    state;
        logic [IR_LEN-1:0] ir_sh;
        logic [IR_LEN-1:0] ir;
        logic [31:0]       dr_sh;
        logic              tdo;
        logic              tdo_oe;
    } dsp_tap_st_t;
    localparam dsp_core_st_t CORE_RST = '0; // All control cleared
    localparam dsp_tap_st_t  TAP_RST  = '0; // Controller in reset
endpackage
`default_nettype wire

/* File: verilog/dsp_top.sv */
// Debug support port: test access port, serial debug link and trace
`timescale 1ns/1ns
`default_nettype none
module dsp_top
    import dsp_pkg::*;
(
    input  wire logic               clk_sys,              // System clock
    input  wire logic               reset_n,              // System reset
    input  wire logic               test_port_select,     // Strap pin
    input  wire logic               trst_n,               // Test reset pin
    input  wire logic               tclk,                 // Test clock pin
    input  wire logic               tms,                  // Test mode pin
    input  wire logic               tdi,                  // Test data pin
    output var  logic               tdo,                  // Test data out
    output var  logic               tdo_oe,               // Test data enable
    input  wire logic               dev_serial_clock,     // Serial clock pin
    input  wire logic               dev_serial_in,        // Serial data pin
    output var  logic               dev_serial_out,       // Serial data out
    input  wire logic               breakpoint_request,   // Breakpoint pin
    input  wire logic               breakpoint_disable,   // Config bit
    input  wire logic               status_clock_disable, // Config bit
    input  wire dsp_core_in_t       core_in,              // Core side
    input  wire logic [PKT_LEN-1:0] pkt_tx_data,          // Next response
    output var  logic [PKT_LEN-1:0] pkt_rx_data,          // Received packet
    output var  logic               pkt_rx_valid,         // Packet strobe
    output var  logic               core_halt_req,        // Halt pending
    output var  logic               core_halted,          // Core halted
    output var  logic               debug_irq,            // Debug interrupt
    output var  logic               jtag_mode,            // Selected mode
    output var  logic [3:0]         processor_status_bus, // Trace status
    output var  logic [3:0]         debug_data_bus,       // Trace data
    output var  logic               status_strobe_clock,  // Trace strobe
    output var  logic               all_status_and        // AND of status
);
    // ********************************
    // State and helpers
    // ********************************
    dsp_core_st_t s_r, s_nxt;    // Core side state
    dsp_tap_st_t  t_r, t_nxt;    // Test port state
    logic         tap_rst_n;     // Either reset clears the test port
    logic         link_en;       // Serial link owns the pins
    logic         tap_en;        // Test port owns the pins
    logic         ds_rise;       // Validated serial clock rise
    logic         bk_rise;       // Breakpoint edge
    logic         tck_rise;      // Test clock edges
    logic         tck_fall;
    logic [3:0]   st;            // Status for this window

    // Standard controller transitions
    function automatic dsp_tap_state_t tap_next(input dsp_tap_state_t s, input logic m);
        unique case (s)
            TAP_RESET:  tap_next = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: tap_next = m ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: tap_next = m ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
        endcase
    endfunction

    assign link_en   = s_r.sel_done & ~s_r.jtag_mode;
    assign tap_en    = s_r.sel_done & s_r.jtag_mode;
    assign tap_rst_n = reset_n & trst_n;

    // ********************************
    // Core side next state
    // ********************************
    always_comb begin
        s_nxt          = s_r;
        s_nxt.rx_valid = 1'b0;
        s_nxt.dbg_irq  = 1'b0;
        ds_rise        = 1'b0;
        st             = s_r.stat;
        // Pin synchronisers
        s_nxt.sel_sh = {s_r.sel_sh[0], test_port_select};
        s_nxt.ds_sh  = {s_r.ds_sh[1:0], dev_serial_clock};
        s_nxt.dsi_sh = {s_r.dsi_sh[0], dev_serial_in};
        s_nxt.bk_sh  = {s_r.bk_sh[1:0], breakpoint_request};
        bk_rise      = s_r.bk_sh[1] & ~s_r.bk_sh[2];
        // Strap caught once the synchroniser has filled after release
        if (!s_r.sel_done) begin
            if (s_r.sel_cnt == SEL_WAIT) begin
                s_nxt.sel_done  = 1'b1;
                s_nxt.jtag_mode = s_r.sel_sh[1];
            end else begin
                s_nxt.sel_cnt = s_r.sel_cnt + 2'h1;
            end
        end
        // Level counts only when two samples agree; filters slow edges
        if (s_r.ds_sh[1] == s_r.ds_sh[2]) begin
            s_nxt.ds_lvl = s_r.ds_sh[1];
            ds_rise      = s_r.ds_sh[1] & ~s_r.ds_lvl & link_en;
        end
        // Host pacing keeps the data sync aligned with the clock sync
        if (ds_rise) begin
            s_nxt.rx_sh   = {s_r.rx_sh[PKT_LEN-2:0], s_r.dsi_sh[1]};
            s_nxt.ser_out = s_r.tx_sh[PKT_LEN-1];
            s_nxt.tx_sh   = {s_r.tx_sh[PKT_LEN-2:0], 1'b0};
            s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
            // Packet complete: hand it over, load the response
            if (s_r.bit_cnt == PKT_LAST) begin
                s_nxt.rx_data  = s_nxt.rx_sh;
                s_nxt.rx_valid = 1'b1;
                s_nxt.tx_sh    = pkt_tx_data;
                s_nxt.bit_cnt  = 5'h00;
            end
        end
        // Halt completes only at an instruction boundary
        if (s_r.halt_pend && core_in.insn_done) begin
            s_nxt.halt_pend = 1'b0;
            s_nxt.halted    = 1'b1;
        end else if (s_r.halted && core_in.resume) begin
            s_nxt.halted = 1'b0;
        end
        // Breakpoint: interrupt when disabled, else request a halt
        if (bk_rise && breakpoint_disable) begin
            s_nxt.dbg_irq = 1'b1;
        end else if (bk_rise && !s_r.halted && !s_r.halt_pend) begin
            s_nxt.halt_pend = 1'b1;
        end
        // Trace divider: window opens on phase 0, strobe rises on phase 1
        // Divider runs on while frozen, so a resume may start on either phase
        s_nxt.tr_ph = ~s_r.tr_ph;
        if (!status_clock_disable) begin
            if (!s_r.tr_ph) begin
                st             = s_r.halted ? STAT_HALT : core_in.status;
                s_nxt.stat     = st;
                s_nxt.stat_and = &st;
                s_nxt.dbg_data = core_in.cap_data;
                s_nxt.strobe   = 1'b0;
                if (st == STAT_C || st == STAT_D || st == STAT_HALT) begin
                    s_nxt.trace_on = 1'b1;
                end
            end else begin
                s_nxt.strobe = s_r.trace_on;
            end
        end
    end

    // ********************************
    // Test port next state
    // ********************************
    always_comb begin
        t_nxt        = t_r;
        t_nxt.tck_sh = {t_r.tck_sh[1:0], tclk};
        t_nxt.tms_sh = {t_r.tms_sh[0], tms};
        t_nxt.tdi_sh = {t_r.tdi_sh[0], tdi};
        tck_rise     = t_r.tck_sh[1] & ~t_r.tck_sh[2] & tap_en;
        tck_fall     = ~t_r.tck_sh[1] & t_r.tck_sh[2] & tap_en;
        // Reset state keeps the identity instruction loaded
        if (t_r.state == TAP_RESET) begin
            t_nxt.ir = IR_IDCODE;
        end
        // Rising edge: shift, capture, update, then advance
        if (tck_rise) begin
            if (t_r.state == TAP_CAP_IR) begin
                t_nxt.ir_sh = IR_CAPTURE;
            end else if (t_r.state == TAP_SH_IR) begin
                t_nxt.ir_sh = {t_r.tdi_sh[1], t_r.ir_sh[IR_LEN-1:1]};
            end else if (t_r.state == TAP_UPD_IR) begin
                t_nxt.ir = t_r.ir_sh;
            end else if (t_r.state == TAP_CAP_DR) begin
                t_nxt.dr_sh = (t_r.ir == IR_IDCODE) ? ID_CODE : 32'h0000_0000;
            end else if (t_r.state == TAP_SH_DR) begin
                // Any other instruction selects the one-bit bypass
                if (t_r.ir == IR_IDCODE) begin
                    t_nxt.dr_sh = {t_r.tdi_sh[1], t_r.dr_sh[31:1]};
                end else begin
                    t_nxt.dr_sh[0] = t_r.tdi_sh[1];
                end
            end
            t_nxt.state = tap_next(t_r.state, t_r.tms_sh[1]);
        end
        // Falling edge: output follows the shift states only
        if (tck_fall) begin
            t_nxt.tdo_oe = (t_r.state == TAP_SH_IR) || (t_r.state == TAP_SH_DR);
            t_nxt.tdo    = (t_r.state == TAP_SH_IR) ? t_r.ir_sh[0] : t_r.dr_sh[0];
        end
        // Pins belong to the serial link: hold the controller in reset
        if (!tap_en) begin
            t_nxt.state  = TAP_RESET;
            t_nxt.tdo_oe = 1'b0;
        end
    end

    // ********************************
    // Registers
    // ********************************
    // Core side, system reset only
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= CORE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Test port, also cleared by test reset without a clock
    always_ff @(posedge clk_sys or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            t_r <= TAP_RST;
        end else begin
            t_r <= t_nxt;
        end
    end

    assign tdo                  = t_r.tdo;
    assign tdo_oe               = t_r.tdo_oe;
    assign dev_serial_out       = s_r.ser_out;
    assign pkt_rx_data          = s_r.rx_data;
    assign pkt_rx_valid         = s_r.rx_valid;
    assign core_halt_req        = s_r.halt_pend;
    assign core_halted          = s_r.halted;
    assign debug_irq            = s_r.dbg_irq;
    assign jtag_mode            = s_r.jtag_mode;
    assign processor_status_bus = s_r.stat;
    assign debug_data_bus       = s_r.dbg_data;
    assign status_strobe_clock  = s_r.strobe;
    assign all_status_and       = s_r.stat_and;

    // ********************************
    // Assertions
    // ********************************
    // Trace port
    a_halt_status: assert property (@(posedge clk_sys) disable iff (!reset_n)
        core_halted && !s_r.tr_ph && !status_clock_disable |=> processor_status_bus == 4'hF)
        else $error("halted status not all ones");
    a_all_and: assert property (@(posedge clk_sys) disable iff (!reset_n)
        all_status_and == (&processor_status_bus))
        else $error("all-status output wrong");
    a_trace_freeze: assert property (@(posedge clk_sys) disable iff (!reset_n)
        status_clock_disable |=> $stable(processor_status_bus) && $stable(status_strobe_clock)
        && $stable(debug_data_bus))
        else $error("trace moved while disabled");
    a_strobe_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(s_r.trace_on) |-> processor_status_bus inside {4'hC, 4'hD, 4'hF})
        else $error("strobe started on wrong code");
    // A freeze may hold the strobe high; that is legal, not a centring fault
    a_strobe_centre: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(status_strobe_clock) |-> $stable(processor_status_bus)
        ##1 (!status_strobe_clock || $past(status_clock_disable)))
        else $error("strobe not centred");
    // Breakpoint and halt
    a_breakpoint_request_irq: assert property (@(posedge clk_sys) disable iff (!reset_n)
        bk_rise && breakpoint_disable |=> debug_irq && !$rose(core_halt_req))
        else $error("disabled breakpoint did not interrupt");
    a_halt_wait: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(core_halted) |-> $past(core_in.insn_done) && $past(core_halt_req))
        else $error("halted before instruction end");
    a_breakpoint_request_halt: assert property (@(posedge clk_sys) disable iff (!reset_n)
        bk_rise && !breakpoint_disable && !core_halted |=> core_halt_req || core_halted)
        else $error("breakpoint ignored");
    // Serial link
    a_sout_edge: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $changed(dev_serial_out) |-> $past(ds_rise))
        else $error("serial out moved without clock rise");
    a_ds_valid: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(s_r.ds_lvl) |-> $past(s_r.ds_sh[1]) && $past(s_r.ds_sh[2]))
        else $error("serial clock validated too early");
    // Test port
    a_tdo_enable: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        $rose(tdo_oe) |-> $past(t_r.state) inside {TAP_SH_IR, TAP_SH_DR} && $past(tck_fall))
        else $error("output enabled outside shift");
    a_tap_step: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        tck_rise && t_r.state == TAP_RESET && !t_r.tms_sh[1] |=> t_r.state == TAP_IDLE)
        else $error("controller did not leave reset");
    a_tdo_shift: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        tck_fall && t_r.state == TAP_SH_DR |=> tdo_oe && tdo == $past(t_r.dr_sh[0]))
        else $error("shift output wrong");
    a_tdo_idle: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        !tap_en |=> !tdo_oe)
        else $error("output driven in link mode");
    a_ir_reset: assert property (@(posedge clk_sys) disable iff (!tap_rst_n)
        t_r.state == TAP_RESET |=> t_r.ir == IR_IDCODE)
        else $error("reset state lost identity instruction");
    // Strap and trace loading
    a_strap_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_r.sel_done |=> $stable(jtag_mode) && s_r.sel_done)
        else $error("strap changed after capture");
    a_status_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !s_r.tr_ph && !status_clock_disable && !core_halted |=> processor_status_bus == $past(core_in.status))
        else $error("status not loaded");
    a_data_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !s_r.tr_ph && !status_clock_disable |=> debug_data_bus == $past(core_in.cap_data))
        else $error("debug data not captured");

    // ********************************
    // Cover points
    // ********************************
    c_trace_start: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(status_strobe_clock));
    c_halted: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(core_halted));
    c_irq: cover property (@(posedge clk_sys) disable iff (!reset_n) debug_irq);
    c_packet: cover property (@(posedge clk_sys) disable iff (!reset_n) pkt_rx_valid);
    c_shift: cover property (@(posedge clk_sys) disable iff (!tap_rst_n) $rose(tdo_oe));
endmodule
`default_nettype wire

/* File: verif/dsp_host_model.sv */
// Development system model that drives the serial debug link
`timescale 1ns/1ns
`default_nettype none
module dsp_host_model
    import dsp_pkg::*;
(
    input  wire logic clk_sys,          // Bench clock, pacing only
    input  wire logic dev_serial_out,   // Device response bit
    output var  logic dev_serial_clock, // Link clock, idle low
    output var  logic dev_serial_in     // Data to the device
);
    // ****************************************
    // Packet transfer
    // ****************************************
    // Half period in clk_sys cycles; 10 cycles a bit runs at strobe/5
    localparam int HALF = 5;
    initial begin
        dev_serial_clock = 1'b0;
        dev_serial_in    = 1'b0;
    end
    // MSB first both ways; clock stands low between frames
    task automatic xfer(input logic [PKT_LEN-1:0] tx, output logic [PKT_LEN-1:0] rx);
        rx = '0;
        for (int i = PKT_LEN - 1; i >= -1; i--) begin
            if (i >= 0) begin
                dev_serial_in <= tx[i];
            end
            repeat (HALF) @(negedge clk_sys);
            // Response of the previous rise is settled by now
            rx = {rx[PKT_LEN-2:0], dev_serial_out};
            if (i >= 0) begin
                dev_serial_clock <= 1'b1;
                repeat (HALF) @(negedge clk_sys);
                dev_serial_clock <= 1'b0;
            end
        end
        // Released data line shows the inverse of its last value
        dev_serial_in <= ~tx[0];
        @(negedge clk_sys);  // Released level stands before any next frame
    endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the debug support port
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module tb_top
    import dsp_pkg::*;
;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic               clk_sys, reset_n, test_port_select, trst_n, tclk, tms, tdi, tdo, tdo_oe;
    logic               dev_serial_clock, dev_serial_in, dev_serial_out;
    logic               breakpoint_request, breakpoint_disable, status_clock_disable;
    dsp_core_in_t       core_in;                   // Core side stimulus
    logic [PKT_LEN-1:0] pkt_tx_data, pkt_rx_data, host_rx;
    logic               pkt_rx_valid, core_halt_req, core_halted, debug_irq, jtag_mode;
    logic [3:0]         processor_status_bus, debug_data_bus;
    logic               status_strobe_clock, all_status_and;
    int                 failures, check_count, valid_seen, irq_seen, rises;
    dsp_top i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .test_port_select(test_port_select),
        .trst_n(trst_n), .tclk(tclk), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .dev_serial_clock(dev_serial_clock), .dev_serial_in(dev_serial_in),
        .dev_serial_out(dev_serial_out), .breakpoint_request(breakpoint_request),
        .breakpoint_disable(breakpoint_disable), .status_clock_disable(status_clock_disable),
        .core_in(core_in), .pkt_tx_data(pkt_tx_data), .pkt_rx_data(pkt_rx_data),
        .pkt_rx_valid(pkt_rx_valid), .core_halt_req(core_halt_req), .core_halted(core_halted),
        .debug_irq(debug_irq), .jtag_mode(jtag_mode), .processor_status_bus(processor_status_bus),
        .debug_data_bus(debug_data_bus), .status_strobe_clock(status_strobe_clock),
        .all_status_and(all_status_and));
    dsp_host_model i_host (.clk_sys(clk_sys), .dev_serial_out(dev_serial_out),
        .dev_serial_clock(dev_serial_clock), .dev_serial_in(dev_serial_in));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Pulse and edge counters, so one-cycle outputs are never missed
    always @(posedge clk_sys) begin
        if (pkt_rx_valid === 1'b1) valid_seen++;
        if (debug_irq === 1'b1) irq_seen++;
    end
    always @(posedge status_strobe_clock) rises++;
    // ****************************************
    // Helpers
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic do_reset(input logic strap);
        reset_n = 1'b0;
        test_port_select = strap;
        cyc(20);
        reset_n = 1'b1;
        cyc(6);
        rises = 0;
        `CHK("jtag_mode", strap, jtag_mode)
    endtask
    // One test clock period; phases long enough for the 2 FF sampling
    task automatic tck(input logic m, input logic d);
        tms = m;
        tdi = d;
        cyc(2);
        tclk = 1'b1;
        cyc(6);
        tclk = 1'b0;
        cyc(6);
    endtask
    task automatic close_out;
        $display("Checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_tap;
        do_reset(1'b1);
        `CHK("oe_idle", 1'b0, tdo_oe)
        tck(0, 0); tck(1, 0); tck(0, 0); tck(0, 0);
        `CHK("oe_shift", 1'b1, tdo_oe)
        for (int i = 0; i < 32; i++) begin
            `CHK("id_bit", ID_CODE[i], tdo)
            tck(0, 1);
        end
        `CHK("tdi_through", 1'b1, tdo)
        tck(1, 0);
        `CHK("oe_exit", 1'b0, tdo_oe)
        tck(0, 0); tck(1, 0); tck(0, 0);
        `CHK("oe_reshift", 1'b1, tdo_oe)
        trst_n = 1'b0;
        #1;
        `CHK("oe_trst", 1'b0, tdo_oe)
        cyc(2);
        trst_n = 1'b1;
        $display("test tap done");
    endtask
    task automatic test_link;
        do_reset(1'b0);
        pkt_tx_data = 17'h1A5C3;
        valid_seen = 0;
        i_host.xfer(17'h0B4E1, host_rx);
        `CHK("rx_pkt", 17'h0B4E1, pkt_rx_data)
        `CHK("rx_pulses", 1, valid_seen)
        `CHK("tx_first", 17'h00000, host_rx)
        pkt_tx_data = 17'h00F0F;
        i_host.xfer(17'h1FFFF, host_rx);
        `CHK("tx_pkt", 17'h1A5C3, host_rx)
        `CHK("rx_pkt2", 17'h1FFFF, pkt_rx_data)
        $display("test link done");
    endtask
    task automatic test_trace;
        `CHK("strobe_quiet", 0, rises)
        core_in.status = STAT_C;
        core_in.cap_data = 4'h6;
        cyc(4);
        rises = 0;
        cyc(20);
        `CHK("strobe_rate", 10, rises)
        `CHK("status", STAT_C, processor_status_bus)
        `CHK("dbg_data", 4'h6, debug_data_bus)
        `CHK("and_low", 1'b0, all_status_and)
        status_clock_disable = 1'b1;
        cyc(2);
        rises = 0;
        core_in.status = STAT_D;
        core_in.cap_data = 4'h9;
        cyc(10);
        `CHK("frozen_strobe", 0, rises)
        `CHK("frozen_status", STAT_C, processor_status_bus)
        `CHK("frozen_data", 4'h6, debug_data_bus)
        status_clock_disable = 1'b0;
        cyc(4);
        `CHK("resume_status", STAT_D, processor_status_bus)
        `CHK("resume_data", 4'h9, debug_data_bus)
        `CHK("resume_strobe", 1'b1, rises > 0)
        $display("test trace done");
    endtask
    task automatic test_break;
        breakpoint_request = 1'b1;
        cyc(6);
        `CHK("halt_req", 1'b1, core_halt_req)
        `CHK("not_yet", 1'b0, core_halted)
        core_in.insn_done = 1'b1;
        cyc(2);
        core_in.insn_done = 1'b0;
        `CHK("halted", 1'b1, core_halted)
        cyc(4);
        `CHK("status_halt", STAT_HALT, processor_status_bus)
        `CHK("and_high", 1'b1, all_status_and)
        breakpoint_request = 1'b0;
        core_in.resume = 1'b1;
        cyc(2);
        core_in.resume = 1'b0;
        `CHK("resumed", 1'b0, core_halted)
        irq_seen = 0;
        breakpoint_disable = 1'b1;
        breakpoint_request = 1'b1;
        cyc(8);
        breakpoint_request = 1'b0;
        `CHK("irq_pulses", 1, irq_seen)
        `CHK("no_halt", 1'b0, core_halt_req | core_halted)
        $display("test break done");
    endtask
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        {tclk, tdi, breakpoint_request} = '0;
        {breakpoint_disable, status_clock_disable, failures, check_count} = '0;
        {trst_n, tms} = 2'h3;
        core_in = '0;
        pkt_tx_data = '0;
        test_tap();
        test_link();
        test_trace();
        test_break();
        close_out();
    end
    // Tests need about 1000 cycles; eight times that means a hang
    initial begin
        repeat (8000) @(posedge clk_sys);
        failures++;
        close_out();
    end
endmodule
`default_nettype wire
